// ==== pbsa_cfg.svh ====
// Constants shared by both ends of the pipelined burst SRAM link
`ifndef PBSA_CFG_SVH
`define PBSA_CFG_SVH
`define PBSA_ADDR_W 18
`define PBSA_DQ_W 16
`define PBSA_PAR_W 2
`define PBSA_LANES 2
`define PBSA_LANE_W 8
`define PBSA_WORD_W 18
`define PBSA_MEM_AW 6
`define PBSA_BEAT_W 2
`define PBSA_FIFO_DEPTH 32
`define PBSA_MEM_RESET 18'h00000
`endif

// ==== pbsa_pkg.sv ====
// Types shared by both ends of the pipelined burst SRAM link
`include "pbsa_cfg.svh"
package pbsa_pkg;
  typedef enum logic [1:0] {
    PBSA_READ,
    PBSA_WRITE,
    PBSA_ADVANCE,
    PBSA_DESELECT
  } pbsa_kind_type;

  typedef struct packed {
    pbsa_kind_type kind;
    logic [`PBSA_ADDR_W-1:0] addr;
    logic [`PBSA_DQ_W-1:0] dq;
    logic [`PBSA_PAR_W-1:0] par;
    logic [`PBSA_LANES-1:0] be_n;
  } pbsa_req_type;
endpackage

// ==== pbsa_link_if.sv ====
// Pin bundle between memory controller and burst SRAM
`timescale 1ns/1ps
`include "pbsa_cfg.svh"
interface pbsa_link_if #(parameter int ADDR_W = `PBSA_ADDR_W);
  logic clk_qualify_n;
  logic chip_sel1_n;
  logic chip_sel2;
  logic chip_sel3_n;
  logic advance_load;
  logic write_en_n;
  logic out_en_n;
  logic [1:0] byte_lane_sel_n;
  logic [ADDR_W-1:0] addr;
  logic [15:0] dev_dq_o;
  logic [1:0] dev_par_o;
  logic dev_dq_oe;
  logic [15:0] host_dq_o;
  logic [1:0] host_par_o;
  logic host_dq_oe;
  logic dev_drive;
  logic [15:0] dq;
  logic [1:0] parity_lines;

  ////////////////////////////////////////////////////////////////////////////
  // Bus resolution; output enable acts without the clock
  assign dev_drive = dev_dq_oe & ~out_en_n;
  assign dq = dev_drive ? dev_dq_o : (host_dq_oe ? host_dq_o : 16'h0000);
  assign parity_lines = dev_drive ? dev_par_o : (host_dq_oe ? host_par_o : 2'h0);

  modport dev (
    input clk_qualify_n, chip_sel1_n, chip_sel2, chip_sel3_n, advance_load,
    input write_en_n, byte_lane_sel_n, addr, dq, parity_lines,
    output dev_dq_o, dev_par_o, dev_dq_oe
  );
  modport host (
    output clk_qualify_n, chip_sel1_n, chip_sel2, chip_sel3_n, advance_load,
    output write_en_n, byte_lane_sel_n, addr, out_en_n,
    output host_dq_o, host_par_o, host_dq_oe,
    input dq, parity_lines
  );
endinterface

// ==== pbsa_fifo.sv ====
// Request FIFO, flip-flop storage
`timescale 1ns/1ps
`include "pbsa_cfg.svh"
module pbsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `PBSA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic full;
    logic empty;
  } pbsa_fifo_state_type;

  pbsa_fifo_state_type q;
  pbsa_fifo_state_type d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  assign in_ready = ~q.full;
  assign out_valid = ~q.empty;
  assign out_data = q.mem[q.rp];
  assign push = in_valid & ~q.full;
  assign pop = out_ready & ~q.empty;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    d.full = (d.cnt == DEPTH[PW:0]);
    d.empty = (d.cnt == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.empty <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== pbsa_host.sv ====
// Controller end: queues requests and drives the SRAM pins
`timescale 1ns/1ps
`include "pbsa_cfg.svh"
module pbsa_host
  import pbsa_pkg::*;
#(
  parameter int ADDR_W = `PBSA_ADDR_W,
  parameter int DEPTH = `PBSA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Request stream
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire pbsa_req_type REQ,
  // Pause the SRAM clock
  input wire logic SUSPEND,
  // Read return
  output logic RD_VALID,
  output logic [`PBSA_WORD_W-1:0] RD_DATA,
  // SRAM pins
  pbsa_link_if.host LNK
);
  if (ADDR_W != `PBSA_ADDR_W) begin : g_chk
    $error("Host address width must match the request type");
  end

  typedef struct packed {
    logic qual_n;
    logic cs_on;
    logic adv;
    logic we_n;
    logic [1:0] be_n;
    logic [ADDR_W-1:0] addr;
    logic oe_n;
    logic drv;
    logic [`PBSA_WORD_W-1:0] wdat;
    logic burst_ok;
    logic burst_wr;
    logic p1_v;
    logic [`PBSA_WORD_W-1:0] p1_d;
    logic p2_v;
    logic [`PBSA_WORD_W-1:0] p2_d;
    logic [2:0] rd_pipe;
    logic rd_v;
    logic [`PBSA_WORD_W-1:0] rd_d;
  } pbsa_host_state_type;

  pbsa_host_state_type q;
  pbsa_host_state_type d;
  pbsa_req_type head;
  logic head_valid;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  pbsa_fifo #(.WIDTH($bits(pbsa_req_type)), .DEPTH(DEPTH)) i_pbsa_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .in_data(REQ),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  // Edges the SRAM ignores are frozen here too, so both pipelines stay aligned
  assign pop = ~q.qual_n & head_valid;

  always_comb begin
    d = q;
    d.qual_n = SUSPEND;
    d.rd_v = 1'b0;
    if (!q.qual_n) begin
      d.rd_v = q.rd_pipe[2];
      d.rd_d = {LNK.parity_lines, LNK.dq};
      d.p2_v = q.p1_v;
      d.p2_d = q.p1_d;
      d.drv = q.p2_v;
      d.wdat = q.p2_d;
      // Output enable stays high unless the SRAM is due to drive
      d.oe_n = ~q.rd_pipe[1];
      d.rd_pipe = {q.rd_pipe[1:0], 1'b0};
      d.p1_v = 1'b0;
      d.adv = 1'b0;
      d.cs_on = 1'b0;
      d.we_n = 1'b1;
      d.be_n = 2'h3;
      if (!head_valid) begin
        d.burst_ok = 1'b0;
      end else begin
        d.be_n = head.be_n;
        d.addr = head.addr;
        case (head.kind)
          PBSA_READ, PBSA_WRITE: begin
            d.cs_on = 1'b1;
            d.we_n = (head.kind != PBSA_WRITE);
            d.burst_ok = 1'b1;
            d.burst_wr = (head.kind == PBSA_WRITE);
            d.p1_v = (head.kind == PBSA_WRITE);
            d.rd_pipe[0] = (head.kind == PBSA_READ);
          end
          PBSA_ADVANCE: begin
            // Advancing with no loaded burst becomes a deselect
            if (q.burst_ok) begin
              d.adv = 1'b1;
              d.p1_v = q.burst_wr;
              d.rd_pipe[0] = ~q.burst_wr;
            end else begin
              d.burst_ok = 1'b0;
            end
          end
          default: begin
            d.burst_ok = 1'b0;
          end
        endcase
        d.p1_d = {head.par, head.dq};
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.we_n <= 1'b1;
      q.be_n <= 2'h3;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign LNK.clk_qualify_n = q.qual_n;
  assign LNK.chip_sel1_n = ~q.cs_on;
  assign LNK.chip_sel2 = q.cs_on;
  assign LNK.chip_sel3_n = ~q.cs_on;
  assign LNK.advance_load = q.adv;
  assign LNK.write_en_n = q.we_n;
  assign LNK.byte_lane_sel_n = q.be_n;
  assign LNK.addr = q.addr;
  assign LNK.out_en_n = q.oe_n;
  assign LNK.host_dq_oe = q.drv;
  assign LNK.host_dq_o = q.wdat[`PBSA_DQ_W-1:0];
  assign LNK.host_par_o = q.wdat[`PBSA_WORD_W-1:`PBSA_DQ_W];
  assign RD_VALID = q.rd_v;
  assign RD_DATA = q.rd_d;
endmodule

// ==== pbsa_sram.sv ====
// SRAM end: pipelined burst access logic with flip-flop storage
`timescale 1ns/1ps
`include "pbsa_cfg.svh"
module pbsa_sram
  import pbsa_pkg::*;
#(
  parameter int ADDR_W = `PBSA_ADDR_W,
  parameter int MEM_AW = `PBSA_MEM_AW
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Burst order strap
  input wire logic BURST_ORDER,
  // Status
  output logic DESELECTED,
  // SRAM pins
  pbsa_link_if.dev LNK
);
  localparam int DEPTH = 1 << MEM_AW;
  localparam int LW = `PBSA_LANE_W + 1;

  if (MEM_AW < `PBSA_BEAT_W || MEM_AW > ADDR_W) begin : g_chk
    $error("Storage address width must lie between 2 and the pin width");
  end

  if (`PBSA_LANES * LW != `PBSA_WORD_W) begin : g_chk_lane
    $error("Lanes of a byte and a parity bit must fill the word");
  end

  typedef logic [`PBSA_WORD_W-1:0] pbsa_word_type;

  typedef struct packed {
    logic [1:0] order_sync;
    logic active;
    logic desel;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [`PBSA_BEAT_W-1:0] start;
    logic [`PBSA_BEAT_W-1:0] beat;
    logic s1_v;
    logic s1_wr;
    logic [MEM_AW-1:0] s1_a;
    logic s2_v;
    logic [MEM_AW-1:0] s2_a;
    logic [1:0] s2_be_n;
    logic [1:0] s1_be_n;
    logic drive;
    pbsa_word_type dout;
    logic [DEPTH-1:0][`PBSA_WORD_W-1:0] mem;
  } pbsa_sram_state_type;

  // Command seen at an edge; hold covers the suspended edges
  typedef enum logic [2:0] {
    PBSA_CMD_HOLD,
    PBSA_CMD_DESEL,
    PBSA_CMD_LOAD,
    PBSA_CMD_BEAT,
    PBSA_CMD_IDLE
  } pbsa_cmd_type;

  pbsa_sram_state_type q;
  pbsa_sram_state_type d;
  logic selected;
  pbsa_word_type bus_word;
  pbsa_word_type rd_word;
  logic [`PBSA_BEAT_W-1:0] next_beat;
  logic [`PBSA_BEAT_W-1:0] next_low;
  logic [ADDR_W-1:0] beat_addr;
  pbsa_cmd_type cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Lane-major storage: lane l holds {parity bit l, data byte l}
  always_comb begin
    for (int l = 0; l < `PBSA_LANES; l++) begin
      bus_word[l*LW +: LW] = {LNK.parity_lines[l], LNK.dq[l*`PBSA_LANE_W +: `PBSA_LANE_W]};
    end
  end

  assign selected = ~LNK.chip_sel1_n & LNK.chip_sel2 & ~LNK.chip_sel3_n;

  // Burst address of the coming beat; only the two low bits move
  assign next_beat = q.beat + 2'h1;
  assign next_low = q.order_sync[1] ? (q.start ^ next_beat) : (q.start + next_beat);
  assign beat_addr = {q.addr[ADDR_W-1:`PBSA_BEAT_W], next_low};

  // One decode per edge; a suspended edge disturbs no state but the strap sync flops
  always_comb begin
    if (LNK.clk_qualify_n) begin
      cmd = PBSA_CMD_HOLD;
    end else if (!LNK.advance_load) begin
      cmd = selected ? PBSA_CMD_LOAD : PBSA_CMD_DESEL;
    end else if (q.active) begin
      cmd = PBSA_CMD_BEAT;
    end else begin
      // Advance with no burst loaded keeps the burst state and starts no access
      cmd = PBSA_CMD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    rd_word = q.mem[q.s1_a];
    // Strap is a pin; two flops before use, not frozen by suspend
    d.order_sync = {q.order_sync[0], BURST_ORDER};
    if (cmd != PBSA_CMD_HOLD) begin
      // Forward a write that commits on this same edge
      if (q.s2_v && q.s2_a == q.s1_a) begin
        for (int l = 0; l < `PBSA_LANES; l++) begin
          if (!q.s2_be_n[l]) begin
            rd_word[l*LW +: LW] = bus_word[l*LW +: LW];
          end
        end
      end
      // Output stage: read from previous edge, write or deselect turns off
      d.drive = q.s1_v & ~q.s1_wr;
      if (q.s1_v && !q.s1_wr) begin
        d.dout = rd_word;
      end
      // Write data phase, two qualified edges after the command
      if (q.s2_v) begin
        for (int l = 0; l < `PBSA_LANES; l++) begin
          if (!q.s2_be_n[l]) begin
            d.mem[q.s2_a][l*LW +: LW] = bus_word[l*LW +: LW];
          end
        end
      end
      d.s2_v = q.s1_v & q.s1_wr;
      d.s2_a = q.s1_a;
      d.s2_be_n = q.s1_be_n;
      // Command stage; never stalls, so reads run back to back
      d.s1_v = 1'b0;
      d.s1_be_n = LNK.byte_lane_sel_n;
      case (cmd)
        PBSA_CMD_LOAD: begin
          d.active = 1'b1;
          d.wr = ~LNK.write_en_n;
          d.addr = LNK.addr;
          d.start = LNK.addr[`PBSA_BEAT_W-1:0];
          d.beat = '0;
          d.s1_v = 1'b1;
          d.s1_wr = ~LNK.write_en_n;
          d.s1_a = LNK.addr[MEM_AW-1:0];
        end
        PBSA_CMD_DESEL: begin
          d.active = 1'b0;
        end
        PBSA_CMD_BEAT: begin
          // Selects and write select are not looked at here
          d.beat = next_beat;
          d.s1_v = 1'b1;
          d.s1_wr = q.wr;
          d.s1_a = beat_addr[MEM_AW-1:0];
        end
        default: begin
          d.active = q.active;
        end
      endcase
    end
    // Status flop follows the next burst state so the pin needs no gate
    d.desel = ~d.active;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.mem <= {DEPTH{`PBSA_MEM_RESET}};
      q.desel <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unpack lanes back onto the pins
  generate
    for (genvar l = 0; l < `PBSA_LANES; l++) begin : g_lane
      assign LNK.dev_dq_o[l*`PBSA_LANE_W +: `PBSA_LANE_W] = q.dout[l*LW +: `PBSA_LANE_W];
      assign LNK.dev_par_o[l] = q.dout[l*LW + `PBSA_LANE_W];
    end
  endgenerate

  // Gated by output enable in the link bundle
  assign LNK.dev_dq_oe = q.drive;
  assign DESELECTED = q.desel;
endmodule

// ==== pbsa_checker.sv ====
// Pin protocol assertions for the burst SRAM link
`timescale 1ns/1ps
module pbsa_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Command pins
  input wire logic clk_qualify_n,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic advance_load,
  input wire logic write_en_n,
  input wire logic out_en_n,
  // Bus drivers
  input wire logic dev_dq_oe,
  input wire logic host_dq_oe,
  input wire logic dev_drive
);
  logic sel;
  logic rd;
  logic wr;
  logic ds;
  logic q;

  ////////////////////////////////////////////////////////////////////////////
  // Qualified command decode
  assign q = ~clk_qualify_n;
  assign sel = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
  assign rd = q & sel & ~advance_load & write_en_n;
  assign wr = q & sel & ~advance_load & ~write_en_n;
  assign ds = q & ~sel & ~advance_load;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_rd_lat; rd ##1 q |=> dev_dq_oe; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_wr_off; wr ##1 q |=> !dev_dq_oe; endproperty
  a_wr_off: assert property (p_wr_off) else $error("drive after write");
  property p_wr_data; wr ##1 q |=> host_dq_oe; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data missing");
  property p_desel; ds ##1 q |=> !dev_dq_oe; endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  property p_first; ds ##1 rd |=> !dev_dq_oe; endproperty
  a_first: assert property (p_first) else $error("drive on first clock");
  property p_hold; clk_qualify_n |=> $stable(dev_dq_oe) && $stable(host_dq_oe); endproperty
  a_hold: assert property (p_hold) else $error("state moved in suspend");
  property p_b2b; rd ##1 rd ##1 q |=> dev_dq_oe && $past(dev_dq_oe); endproperty
  a_b2b: assert property (p_b2b) else $error("gap between reads");
  property p_adv; rd ##1 (q & advance_load) ##1 q |=> dev_dq_oe; endproperty
  a_adv: assert property (p_adv) else $error("burst beat lost");
  property p_oe; rd ##1 q |=> !out_en_n; endproperty
  a_oe: assert property (p_oe) else $error("enable high during read data");
  property p_cont; !(dev_drive && host_dq_oe); endproperty
  a_cont: assert property (p_cont) else $error("bus contention");
  property p_rst; $rose(RST_N) |-> !dev_dq_oe; endproperty
  a_rst: assert property (p_rst) else $error("drive after reset");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for both ends of the burst SRAM link
`timescale 1ns/1ps
module tb_top
  import pbsa_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  pbsa_req_type req = '0;
  logic suspend = 1'b0;
  logic burst_order = 1'b0;
  logic rd_valid;
  logic [17:0] rd_data;
  logic deselected;
  logic [17:0] mem_m [64];
  logic [17:0] exp_q [$];
  logic [17:0] got_q [$];
  int n_errors = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Both ends joined by the pin bundle
  pbsa_link_if lnk ();
  pbsa_host i_pbsa_host (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .SUSPEND(suspend), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .LNK(lnk.host));
  pbsa_sram i_pbsa_sram (.CLK(clk), .RST_N(rst_n), .BURST_ORDER(burst_order),
    .DESELECTED(deselected), .LNK(lnk.dev));
  pbsa_checker i_pbsa_checker (.CLK(clk), .RST_N(rst_n),
    .clk_qualify_n(lnk.clk_qualify_n), .chip_sel1_n(lnk.chip_sel1_n),
    .chip_sel2(lnk.chip_sel2), .chip_sel3_n(lnk.chip_sel3_n),
    .advance_load(lnk.advance_load), .write_en_n(lnk.write_en_n),
    .out_en_n(lnk.out_en_n), .dev_dq_oe(lnk.dev_dq_oe),
    .host_dq_oe(lnk.host_dq_oe), .dev_drive(lnk.dev_drive));

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      got_q.push_back(rd_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Pushes are held back by suspend so a burst streams without gaps
  task automatic hold();
    @(negedge clk);
    suspend = 1'b1;
  endtask

  task automatic push(input pbsa_kind_type k, input logic [17:0] a, input logic [17:0] d,
      input logic [1:0] be);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{k, a, d[15:0], d[17:16], be};
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      chk(18'h00001, 18'h00000);
      end_of_test();
    end
  endtask

  // Model update by lane: parity bit l rides with byte l
  task automatic wr(input pbsa_kind_type k, input logic [17:0] a, input logic [17:0] d,
      input logic [1:0] be);
    push(k, a, d, be);
    if (!be[0]) begin
      mem_m[a[5:0]][7:0] = d[7:0];
      mem_m[a[5:0]][16] = d[16];
    end
    if (!be[1]) begin
      mem_m[a[5:0]][15:8] = d[15:8];
      mem_m[a[5:0]][17] = d[17];
    end
  endtask

  task automatic rd(input pbsa_kind_type k, input logic [17:0] a);
    push(k, a, 18'h00000, 2'h3);
    exp_q.push_back(mem_m[a[5:0]]);
  endtask

  task automatic flush();
    int n;
    @(negedge clk);
    req_valid = 1'b0;
    suspend = 1'b0;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (8) @(negedge clk);
    chk(18'(got_q.size()), 18'(exp_q.size()));
    if (n == 500) begin
      end_of_test();
    end
    while (got_q.size() > 0 && exp_q.size() > 0) begin
      chk(got_q.pop_front(), exp_q.pop_front());
    end
    got_q = {};
    exp_q = {};
  endtask

  function automatic logic [17:0] ba(input logic [17:0] b, input logic [1:0] s, input int n,
      input logic o);
    ba = {b[17:2], o ? s ^ 2'(n) : s + 2'(n)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({17'h00000, deselected}, 18'h00001);
    chk({17'h00000, lnk.dev_dq_oe}, 18'h00000);
    chk({17'h00000, req_ready}, 18'h00001);
  endtask

  task automatic t_lanes();
    hold();
    wr(PBSA_WRITE, 18'h00014, 18'h3FFFF, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(PBSA_WRITE, 18'h00014, 18'h2C3A5 + 18'(i) * 18'h1111B, 2'(i));
      rd(PBSA_READ, 18'h00014);
    end
    rd(PBSA_READ, 18'h00014);
    flush();
  endtask

  task automatic t_burst(input logic o);
    logic [17:0] b;
    logic [1:0] s;
    b = 18'h00020 + 18'(o) * 18'h00004;
    s = 2'(o) + 2'h1;
    @(negedge clk);
    burst_order = o;
    repeat (4) @(negedge clk);
    hold();
    wr(PBSA_WRITE, ba(b, s, 0, o), 18'h10F01, 2'h0);
    for (int n = 1; n < 4; n++) begin
      wr(PBSA_ADVANCE, ba(b, s, n, o), 18'h20E10 + 18'(n), (n == 2) ? 2'h2 : 2'h0);
    end
    for (int n = 0; n < 4; n++) begin
      rd(PBSA_READ, b + 18'(n));
    end
    rd(PBSA_READ, ba(b, s, 0, o));
    for (int n = 1; n < 5; n++) begin
      rd(PBSA_ADVANCE, ba(b, s, n, o));
    end
    flush();
  endtask

  task automatic t_desel();
    hold();
    rd(PBSA_READ, 18'h00028);
    @(negedge clk);
    req_valid = 1'b0;
    suspend = 1'b0;
    repeat (3) @(negedge clk);
    chk({17'h00000, deselected}, 18'h00000);
    flush();
    chk({17'h00000, deselected}, 18'h00001);
    hold();
    push(PBSA_ADVANCE, 18'h00000, 18'h00000, 2'h3);
    rd(PBSA_READ, 18'h00021);
    push(PBSA_DESELECT, 18'h00000, 18'h00000, 2'h3);
    rd(PBSA_READ, 18'h00022);
    flush();
  endtask

  task automatic t_fifo();
    int n;
    hold();
    n = 0;
    @(negedge clk);
    while (req_ready === 1'b1 && n < 40) begin
      req_valid = 1'b1;
      req = '{PBSA_READ, 18'(n), 16'h0000, 2'h0, 2'h3};
      exp_q.push_back(mem_m[n]);
      n++;
      @(negedge clk);
    end
    chk(18'(n), 18'h00020);
    flush();
  endtask

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem_m[i] = 18'h00000;
    end
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_lanes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_desel();
    t_fifo();
    end_of_test();
  end
endmodule
